// File: include/rxagc_defines.svh
// Constants of the receiver input, gain control and strength block
`ifndef RXAGC_DEFINES_SVH
`define RXAGC_DEFINES_SVH
// Register addresses
`define RXAGC_ADDR_CHIP_CTRL 5'h00
`define RXAGC_ADDR_PROTO 5'h01
`define RXAGC_ADDR_RX_SPECIAL 5'h0a
`define RXAGC_ADDR_STATUS 5'h0f
// Field positions
`define RXAGC_BIT_SWAP 3
`define RXAGC_BIT_AGC_ON 2
`define RXAGC_BIT_AGC_LOW_TRIG 1
`define RXAGC_BIT_NO_FREEZE 0
`define RXAGC_BIT_OSC_OK 6
`define RXAGC_BIT_UNUSED 7
`define RXAGC_AUX_MSB 5
`define RXAGC_AUX_LSB 3
`define RXAGC_MAIN_MSB 2
`define RXAGC_MAIN_LSB 0
// Reset values
`define RXAGC_RST_CHIP_CTRL 8'h00
`define RXAGC_RST_PROTO 8'h02
`define RXAGC_RST_RX_SPECIAL 8'h40
// Receive filter presets per standard group
`define RXAGC_PRESET_GRP0 8'h40
`define RXAGC_PRESET_GRP1 8'h20
`define RXAGC_PRESET_GRP2 8'h10
`define RXAGC_PRESET_GRP3 8'h30
// Gain control
`define RXAGC_AGC_THRESH 10'h010
`define RXAGC_TRIG_MULT_HIGH 10'd5
`define RXAGC_TRIG_MULT_LOW 10'd3
`define RXAGC_GAIN_STEP_MAX 2'd3
`define RXAGC_FREEZE_PULSES 3'd4
// Strength steps, 4 dB apart, one sample count = 0.25 mV
`define RXAGC_LVL_1 8'h08
`define RXAGC_LVL_2 8'h0d
`define RXAGC_LVL_3 8'h14
`define RXAGC_LVL_4 8'h20
`define RXAGC_LVL_5 8'h34
`define RXAGC_LVL_6 8'h50
`define RXAGC_LVL_7 8'h80
`endif

// File: include/rxagc_pkg.sv
// Types and shared functions of the receiver control block
package rxagc_pkg;
`include "rxagc_defines.svh"

  typedef logic [7:0] rxagc_level_t;
  typedef logic [2:0] rxagc_code_t;
  typedef logic [1:0] rxagc_gain_t;

  typedef enum logic [2:0]
  {
    AGC_IDLE = 3'b001,
    AGC_TRACK = 3'b010,
    AGC_FROZEN = 3'b100
  } rxagc_agc_state_t;

  function automatic rxagc_code_t rxagc_quantize(input rxagc_level_t lvl);
    if (lvl >= `RXAGC_LVL_7) return 3'h7;
    else if (lvl >= `RXAGC_LVL_6) return 3'h6;
    else if (lvl >= `RXAGC_LVL_5) return 3'h5;
    else if (lvl >= `RXAGC_LVL_4) return 3'h4;
    else if (lvl >= `RXAGC_LVL_3) return 3'h3;
    else if (lvl >= `RXAGC_LVL_2) return 3'h2;
    else if (lvl >= `RXAGC_LVL_1) return 3'h1;
    else return 3'h0;
  endfunction : rxagc_quantize

  function automatic logic [7:0] rxagc_preset(input logic [7:0] proto);
    case (proto[4:3])
      2'h0: return `RXAGC_PRESET_GRP0;
      2'h1: return `RXAGC_PRESET_GRP1;
      2'h2: return `RXAGC_PRESET_GRP2;
      default: return `RXAGC_PRESET_GRP3;
    endcase
  endfunction : rxagc_preset

  function automatic logic [9:0] rxagc_trigger(input logic low);
    return `RXAGC_AGC_THRESH * (low ? `RXAGC_TRIG_MULT_LOW : `RXAGC_TRIG_MULT_HIGH);
  endfunction : rxagc_trigger
endpackage : rxagc_pkg

// File: design/rxagc_peak.sv
// Peak-hold strength latch for one receive channel
`timescale 1ns/10ps
`include "rxagc_defines.svh"
module rxagc_peak
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_measure,
  input wire rxagc_pkg::rxagc_level_t i_level,
  // Held code
  output rxagc_pkg::rxagc_code_t o_code
);
  import rxagc_pkg::*;

  rxagc_code_t code_now;
  assign code_now = rxagc_quantize(i_level);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_clear)
      o_code <= 3'h0;
    else if (i_measure && (code_now > o_code))
      o_code <= code_now;
  end

  chk_peak_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clear |=> (o_code == 3'h0))
    else $error("strength not cleared by transmission");

  chk_peak_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_clear |=> (o_code >= $past(o_code)))
    else $error("held strength dropped");

  chk_peak_track: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_clear && i_measure) |=> (o_code >= $past(code_now)))
    else $error("strength peak missed");
endmodule : rxagc_peak

// File: design/rxagc_agc.sv
// Automatic gain control sequencer of the main channel
`timescale 1ns/10ps
`include "rxagc_defines.svh"
module rxagc_agc
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_enable,
  input wire logic i_low_trigger,
  input wire logic i_no_freeze,
  // Reception
  input wire logic i_clear,
  input wire logic i_rx_active,
  input wire logic i_subcarrier_pulse,
  input wire rxagc_pkg::rxagc_level_t i_level,
  // Gain state
  output rxagc_pkg::rxagc_gain_t o_gain_cut,
  output logic o_frozen
);
  import rxagc_pkg::*;

  rxagc_agc_state_t state;
  rxagc_agc_state_t next_state;
  logic [2:0] pulse_cnt;
  logic over;
  logic last_pulse;

  assign over = {2'b00, i_level} > rxagc_trigger(i_low_trigger);
  assign last_pulse = i_subcarrier_pulse && (pulse_cnt == (`RXAGC_FREEZE_PULSES - 3'd1));

  always_comb
  begin
    next_state = state;
    case (state)
      AGC_IDLE:
        if (i_enable && i_rx_active)
          next_state = AGC_TRACK;
      AGC_TRACK:
        if (!i_enable || !i_rx_active)
          next_state = AGC_IDLE;
        else if (last_pulse && !i_no_freeze)
          next_state = AGC_FROZEN;
      AGC_FROZEN:
        if (!i_enable || !i_rx_active)
          next_state = AGC_IDLE;
        else if (i_no_freeze)
          next_state = AGC_TRACK;
      default:
        next_state = AGC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state <= AGC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || state == AGC_IDLE)
      pulse_cnt <= 3'h0;
    else if (i_subcarrier_pulse && pulse_cnt != 3'h7)
      pulse_cnt <= pulse_cnt + 3'h1;
  end

  // one step per pulse when too strong
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_enable || i_clear)
      o_gain_cut <= 2'h0;
    else if (state == AGC_TRACK && i_subcarrier_pulse && over
             && o_gain_cut != `RXAGC_GAIN_STEP_MAX)
      o_gain_cut <= o_gain_cut + 2'h1;
  end

  assign o_frozen = (state == AGC_FROZEN);

  chk_agc_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == AGC_FROZEN && !i_clear && i_enable) |=> (o_gain_cut == $past(o_gain_cut)))
    else $error("gain moved while frozen");

  chk_agc_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == AGC_TRACK && i_subcarrier_pulse && over && i_enable && !i_clear
     && o_gain_cut != `RXAGC_GAIN_STEP_MAX) |=> (o_gain_cut == $past(o_gain_cut) + 2'h1))
    else $error("gain not reduced above trigger");

  chk_agc_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    (!over && i_enable && !i_clear) |=> (o_gain_cut == $past(o_gain_cut)))
    else $error("gain reduced below trigger");
endmodule : rxagc_agc

// File: design/rxagc_top.sv
// Receiver input routing, gain control setup and strength status block
`timescale 1ns/10ps
`include "rxagc_defines.svh"
//
// Overview of operation
// - Swap bit B3 of register 00 routes inputs
// - Swap clear: first main; set exchanges
// - Tag response measures both strengths into 0F
// - Protocol write loads presets; 0A overrides
// - Gain control active only while B2 set
// - Reduce gain when level exceeds trigger
// - Trigger five times threshold, three if B1
// - Gain settles within four sub-carrier pulses
// - Gain frozen after first pulses unless B0
// - Measure demodulated, RF amplitude during command
// - Hold peak strength after packet end
// - Clear strengths at each reader transmission
// - Three-bit code, seven 4 dB steps
// - 0F: B6 oscillator, aux B5-B3, main B2-B0
module rxagc_top
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Analog levels, asynchronous
  input wire rxagc_pkg::rxagc_level_t i_rf_input_first,
  input wire rxagc_pkg::rxagc_level_t i_rf_input_second,
  input wire rxagc_pkg::rxagc_level_t i_rf_ampl_first,
  input wire rxagc_pkg::rxagc_level_t i_rf_ampl_second,
  input wire logic i_osc_stable,
  // Reader sequencing, same clock
  input wire logic i_tx_start,
  input wire logic i_rx_active,
  input wire logic i_subcarrier_pulse,
  input wire logic i_rf_ampl_cmd,
  // Receive channels
  output rxagc_pkg::rxagc_level_t o_main_channel,
  output rxagc_pkg::rxagc_level_t o_aux_channel,
  output logic o_input_swap_select,
  // Analog settings
  output rxagc_pkg::rxagc_gain_t o_agc_gain_cut,
  output logic o_agc_frozen,
  output logic [7:0] o_rx_special,
  output logic [7:0] o_proto
);
  import rxagc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Levels are assumed to move slowly against the clock; a sample
  // caught mid-change only costs one wrong sample, never a lock-up.
  rxagc_level_t first_meta;
  rxagc_level_t first_s;
  rxagc_level_t second_meta;
  rxagc_level_t second_s;
  rxagc_level_t ampl1_meta;
  rxagc_level_t ampl1_s;
  rxagc_level_t ampl2_meta;
  rxagc_level_t ampl2_s;
  logic osc_meta;
  logic osc_s;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      first_meta <= 8'h00;
      first_s <= 8'h00;
      second_meta <= 8'h00;
      second_s <= 8'h00;
      ampl1_meta <= 8'h00;
      ampl1_s <= 8'h00;
      ampl2_meta <= 8'h00;
      ampl2_s <= 8'h00;
      osc_meta <= 1'b0;
      osc_s <= 1'b0;
    end
    else
    begin
      first_meta <= i_rf_input_first;
      first_s <= first_meta;
      second_meta <= i_rf_input_second;
      second_s <= second_meta;
      ampl1_meta <= i_rf_ampl_first;
      ampl1_s <= ampl1_meta;
      ampl2_meta <= i_rf_ampl_second;
      ampl2_s <= ampl2_meta;
      osc_meta <= i_osc_stable;
      osc_s <= osc_meta;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] chip_ctrl;
  logic [7:0] proto;
  logic [7:0] rx_special;
  logic wr_chip;
  logic wr_proto;
  logic wr_special;

  assign wr_chip = i_reg_wr && (i_reg_addr == `RXAGC_ADDR_CHIP_CTRL);
  assign wr_proto = i_reg_wr && (i_reg_addr == `RXAGC_ADDR_PROTO);
  assign wr_special = i_reg_wr && (i_reg_addr == `RXAGC_ADDR_RX_SPECIAL);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      chip_ctrl <= `RXAGC_RST_CHIP_CTRL;
    else if (wr_chip)
      chip_ctrl <= i_reg_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      proto <= `RXAGC_RST_PROTO;
      rx_special <= `RXAGC_RST_RX_SPECIAL;
    end
    else if (wr_proto)
    begin
      proto <= i_reg_wdata;
      rx_special <= rxagc_preset(i_reg_wdata);
    end
    else if (wr_special)
      rx_special <= i_reg_wdata;
  end

  logic swap;
  logic agc_on;
  assign swap = chip_ctrl[`RXAGC_BIT_SWAP];
  assign agc_on = chip_ctrl[`RXAGC_BIT_AGC_ON];
  assign o_input_swap_select = swap;
  assign o_rx_special = rx_special;
  assign o_proto = proto;

  // ****************************************
  // Input routing
  // ****************************************
  rxagc_level_t meas_main;
  rxagc_level_t meas_aux;

  // clear keeps first input on main
  // host sets swap for stronger input
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_main_channel <= 8'h00;
      o_aux_channel <= 8'h00;
    end
    else
    begin
      o_main_channel <= swap ? second_s : first_s;
      o_aux_channel <= swap ? first_s : second_s;
    end
  end

  always_comb
  begin
    if (i_rf_ampl_cmd)
    begin
      meas_main = swap ? ampl2_s : ampl1_s;
      meas_aux = swap ? ampl1_s : ampl2_s;
    end
    else
    begin
      meas_main = o_main_channel;
      meas_aux = o_aux_channel;
    end
  end

  // ****************************************
  // Gain control
  // ****************************************
  rxagc_agc u_agc
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_enable(agc_on),
    .i_low_trigger(rx_special[`RXAGC_BIT_AGC_LOW_TRIG]),
    .i_no_freeze(rx_special[`RXAGC_BIT_NO_FREEZE]),
    .i_clear(i_tx_start),
    .i_rx_active(i_rx_active),
    .i_subcarrier_pulse(i_subcarrier_pulse),
    .i_level(o_main_channel),
    .o_gain_cut(o_agc_gain_cut),
    .o_frozen(o_agc_frozen)
  );

  // ****************************************
  // Strength measurement
  // ****************************************
  rxagc_code_t main_code;
  rxagc_code_t aux_code;
  logic measure;
  logic aux_strength_msb;
  logic [1:0] aux_strength_lower_bits;

  assign measure = i_rx_active || i_rf_ampl_cmd;

  rxagc_peak u_peak_main
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(i_tx_start),
    .i_measure(measure),
    .i_level(meas_main),
    .o_code(main_code)
  );

  rxagc_peak u_peak_aux
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(i_tx_start),
    .i_measure(measure),
    .i_level(meas_aux),
    .o_code(aux_code)
  );

  assign aux_strength_msb = aux_code[2];
  assign aux_strength_lower_bits = aux_code[1:0];

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] status;

  always_comb
  begin
    status = 8'h00;
    status[`RXAGC_BIT_UNUSED] = 1'b0;
    status[`RXAGC_BIT_OSC_OK] = osc_s;
    status[`RXAGC_AUX_MSB] = aux_strength_msb;
    status[`RXAGC_AUX_MSB-1:`RXAGC_AUX_LSB] = aux_strength_lower_bits;
    status[`RXAGC_MAIN_MSB:`RXAGC_MAIN_LSB] = main_code;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == `RXAGC_ADDR_CHIP_CTRL)
        o_reg_rdata <= chip_ctrl;
      else if (i_reg_addr == `RXAGC_ADDR_PROTO)
        o_reg_rdata <= proto;
      else if (i_reg_addr == `RXAGC_ADDR_RX_SPECIAL)
        o_reg_rdata <= rx_special;
      else if (i_reg_addr == `RXAGC_ADDR_STATUS)
        o_reg_rdata <= status;
      else
        o_reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_proto_write;
    i_reg_wr && (i_reg_addr == `RXAGC_ADDR_PROTO);
  endsequence

  sequence seq_quiet_link;
    !i_tx_start && !measure;
  endsequence

  chk_swap_route: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (o_main_channel == ($past(swap) ? $past(second_s) : $past(first_s))))
    else $error("main channel routed from wrong input");

  chk_aux_route: assert property (@(posedge i_clk) disable iff (i_rst)
    !swap |=> (o_aux_channel == $past(second_s)))
    else $error("aux channel not second input by default");

  chk_preset_load: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_proto_write |=> (rx_special == rxagc_preset($past(i_reg_wdata))))
    else $error("presets not loaded on standard select");

  chk_agc_disable: assert property (@(posedge i_clk) disable iff (i_rst)
    !agc_on |=> (o_agc_gain_cut == 2'h0))
    else $error("gain cut while control disabled");

  chk_tx_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_tx_start |=> (status[5:0] == 6'h00) ##1 (status[5:0] == 6'h00 || $past(measure)))
    else $error("strength not cleared at transmission");

  chk_status_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    o_reg_rdata[7] == 1'b0 || $past(i_reg_addr) != `RXAGC_ADDR_STATUS || !$past(i_reg_rd))
    else $error("unused status bit set");

  chk_status_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == `RXAGC_ADDR_STATUS) |=> (o_reg_rdata == $past(status)))
    else $error("status read returned wrong value");

  chk_read_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_quiet_link ##1 seq_quiet_link |-> (status[5:0] == $past(status[5:0])))
    else $error("strength changed without measurement");

  // pulses seen since gain control began
  logic settle_run;
  logic [2:0] settle_cnt;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      settle_run <= 1'b0;
    else
      settle_run <= agc_on && i_rx_active;
  end

  // First active cycle skipped, as the sequencer leaves idle then
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !(agc_on && i_rx_active))
      settle_cnt <= 3'h0;
    else if (settle_run && i_subcarrier_pulse && settle_cnt != 3'h7)
      settle_cnt <= settle_cnt + 3'h1;
  end

  sequence seq_fourth_pulse;
    settle_cnt == 3'h3 && settle_run && agc_on && i_rx_active && i_subcarrier_pulse
      && !rx_special[`RXAGC_BIT_NO_FREEZE];
  endsequence

  chk_freeze_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_fourth_pulse |=> o_agc_frozen)
    else $error("gain not settled after four pulses");
endmodule : rxagc_top

// File: dv/rxagc_tag_model.sv
// Tag response seen through the external filter network
`timescale 1ns/10ps
module rxagc_tag_model
(
  // Clock
  input wire logic i_clk,
  // Response request
  input wire logic i_go,
  input wire logic [7:0] i_first_pk,
  input wire logic [7:0] i_second_pk,
  input wire logic [2:0] i_pulses,
  // Filter outputs
  output logic [7:0] o_first,
  output logic [7:0] o_second,
  output logic o_rx_active,
  output logic o_pulse,
  output logic o_tail,
  output logic o_busy
);
  logic [6:0] t = 7'h00;
  logic run = 1'b0;
  logic [6:0] e;
  logic pk;
  logic [7:0] noise;
  // ************
  // Response timeline
  // ************
  assign e = 7'd10 + {1'b0, i_pulses, 3'b000};
  always @(posedge i_clk)
  begin
    t <= i_go ? 7'h00 : t + 7'h01;
    if (i_go)
      run <= 1'b1;
    else if (t == e)
      run <= 1'b0;
  end
  // Noise stays below the weakest step and changes every cycle
  assign noise = {5'h00, t[2:0] ^ 3'h5};
  assign pk = run && t >= 7'd2 && t < e - 7'd1;
  assign o_first = pk ? i_first_pk : noise;
  assign o_second = pk ? i_second_pk : ~noise & 8'h07;
  assign o_busy = run;
  assign o_rx_active = run && t >= 7'd4 && t < e;
  assign o_tail = run && t >= e - 7'd3 && t < e;
  assign o_pulse = run && t >= 7'd8 && t < e - 7'd2 && t[2:0] == 3'h0;
endmodule : rxagc_tag_model

// File: dv/rxagc_top_tb.sv
// Self-checking bench of the receiver control block
`timescale 1ns/10ps
`include "rxagc_defines.svh"
module rxagc_top_tb;
  import rxagc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc = 1'b1;
  logic txs = 1'b0;
  logic acmd = 1'b0;
  logic go = 1'b0;
  logic sw = 1'b0;
  logic [2:0] npul = 3'h0;
  rxagc_level_t fpk = 8'h00;
  rxagc_level_t spk = 8'h00;
  rxagc_level_t amf = 8'h00;
  rxagc_level_t ams = 8'h00;
  rxagc_level_t inf, ins, mainc, auxc, fv, sv;
  logic [7:0] rdata, spec, proto, rv, st;
  logic rxa, pls, tail, busy, swp, frz, aon, b1, b0, ef, gf;
  rxagc_gain_t cut, ec, gc;
  logic [2:0] n, qm, qa;
  logic [16:0] agc_tab [7];
  logic [31:0] seed = 32'd70;
  int bad_count = 0;
  int n_checks = 0;
  always #2.5 i_clk = ~i_clk;
  rxagc_tag_model tag
  (
    .i_clk(i_clk), .i_go(go), .i_first_pk(fpk), .i_second_pk(spk), .i_pulses(npul),
    .o_first(inf), .o_second(ins), .o_rx_active(rxa), .o_pulse(pls), .o_tail(tail),
    .o_busy(busy)
  );
  rxagc_top dut
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_rf_input_first(inf), .i_rf_input_second(ins),
    .i_rf_ampl_first(amf), .i_rf_ampl_second(ams), .i_osc_stable(osc), .i_tx_start(txs),
    .i_rx_active(rxa), .i_subcarrier_pulse(pls), .i_rf_ampl_cmd(acmd),
    .o_main_channel(mainc), .o_aux_channel(auxc), .o_input_swap_select(swp),
    .o_agc_gain_cut(cut), .o_agc_frozen(frz), .o_rx_special(spec), .o_proto(proto)
  );
  // ************
  // Expectations and stimulus helpers
  // ************
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  function automatic logic [2:0] q(input logic [7:0] l);
    logic [7:0] th [7];
    logic [2:0] c;
    th = '{`RXAGC_LVL_1, `RXAGC_LVL_2, `RXAGC_LVL_3, `RXAGC_LVL_4,
      `RXAGC_LVL_5, `RXAGC_LVL_6, `RXAGC_LVL_7};
    c = 3'h0;
    for (int i = 0; i < 7; i++)
      if (l >= th[i])
        c = 3'(i + 1);
    return c;
  endfunction : q
  function automatic logic [7:0] pre(input logic [1:0] g);
    case (g)
      2'h0: return `RXAGC_PRESET_GRP0;
      2'h1: return `RXAGC_PRESET_GRP1;
      2'h2: return `RXAGC_PRESET_GRP2;
      default: return `RXAGC_PRESET_GRP3;
    endcase
  endfunction : pre
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrreg(input logic [4:0] a, input logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
    @(negedge i_clk);
  endtask : wrreg
  task automatic rdreg(input logic [4:0] a, output logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask : rdreg
  task automatic txpulse();
    @(negedge i_clk);
    txs = 1'b1;
    @(negedge i_clk);
    txs = 1'b0;
    @(negedge i_clk);
  endtask : txpulse
  task automatic resp(input logic [7:0] f, input logic [7:0] s, input logic [2:0] np);
    @(negedge i_clk);
    fpk = f;
    spk = s;
    npul = np;
    go = 1'b1;
    @(negedge i_clk);
    go = 1'b0;
    for (int i = 0; i < 200 && tail !== 1'b1; i++)
      @(negedge i_clk);
    chk("main_channel", sw ? s : f, mainc);
    chk("aux_channel", sw ? f : s, auxc);
    gc = cut;
    gf = frz;
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      @(negedge i_clk);
  endtask : resp
  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // ************
  // Scenarios
  // ************
  initial
  begin
    // Gain control cases: on, B1, B0, level, pulses, cut, frozen
    agc_tab = '{{3'b000, 8'hff, 3'd4, 2'd0, 1'b0}, {3'b100, 8'h40, 3'd3, 2'd0, 1'b0},
      {3'b110, 8'h40, 3'd2, 2'd2, 1'b0}, {3'b100, 8'h51, 3'd5, 2'd3, 1'b1},
      {3'b101, 8'h51, 3'd5, 2'd3, 1'b0}, {3'b100, 8'h50, 3'd2, 2'd0, 1'b0},
      {3'b110, 8'h31, 3'd1, 2'd1, 1'b0}};
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    chk("proto", `RXAGC_RST_PROTO, proto);
    chk("rx_special", `RXAGC_RST_RX_SPECIAL, spec);
    chk("swap", 8'h00, {7'h00, swp});
    // Let the synchronisers fill before the first status read
    repeat (3) @(negedge i_clk);
    rdreg(`RXAGC_ADDR_STATUS, rv);
    chk("status", 8'h40, rv);
    wrreg(`RXAGC_ADDR_STATUS, 8'hff);
    wrreg(5'h1f, 8'hff);
    rdreg(`RXAGC_ADDR_STATUS, rv);
    chk("status_ro", 8'h40, rv);
    rdreg(5'h1f, rv);
    chk("unmapped", 8'h00, rv);
    for (int g = 0; g < 4; g++)
    begin
      rv = rnd8();
      rv[4:3] = 2'(g);
      wrreg(`RXAGC_ADDR_PROTO, rv);
      chk("proto", rv, proto);
      chk("preset", pre(rv[4:3]), spec);
    end
    wrreg(`RXAGC_ADDR_RX_SPECIAL, 8'h5c);
    chk("override", 8'h5c, spec);
    for (int k = 0; k < 8; k++)
    begin
      fv = (k == 0) ? 8'h07 : (k == 1) ? 8'h80 : rnd8();
      sv = (k == 0) ? 8'h08 : (k == 1) ? 8'h7f : rnd8();
      amf = rnd8();
      ams = rnd8();
      wrreg(`RXAGC_ADDR_CHIP_CTRL, {4'h0, sw, 3'h0});
      chk("swap", {7'h00, sw}, {7'h00, swp});
      txpulse();
      resp(fv, sv, 3'd2);
      rdreg(`RXAGC_ADDR_STATUS, rv);
      qm = q(sw ? sv : fv);
      qa = q(sw ? fv : sv);
      chk("strength", {2'b01, qa, qm}, rv);
      rdreg(`RXAGC_ADDR_STATUS, st);
      chk("strength_again", rv, st);
      sw = (qa > qm) ? ~sw : sw;
    end
    osc = 1'b0;
    txpulse();
    rdreg(`RXAGC_ADDR_STATUS, rv);
    chk("cleared", 8'h00, rv);
    osc = 1'b1;
    sw = 1'b0;
    wrreg(`RXAGC_ADDR_CHIP_CTRL, 8'h00);
    amf = rnd8() | 8'h10;
    ams = rnd8() | 8'h10;
    txpulse();
    acmd = 1'b1;
    repeat (10) @(negedge i_clk);
    acmd = 1'b0;
    rdreg(`RXAGC_ADDR_STATUS, rv);
    chk("ampl_strength", {2'b01, q(ams), q(amf)}, rv);
    for (int k = 0; k < 7; k++)
    begin
      {aon, b1, b0, fv, n, ec, ef} = agc_tab[k];
      wrreg(`RXAGC_ADDR_RX_SPECIAL, {6'h10, b1, b0});
      wrreg(`RXAGC_ADDR_CHIP_CTRL, {5'h00, aon, 2'b00});
      txpulse();
      chk("cut_cleared", 8'h00, {6'h00, cut});
      resp(fv, rnd8(), n);
      chk("gain_cut", {6'h00, ec}, {6'h00, gc});
      chk("frozen", {7'h00, ef}, {7'h00, gf});
    end
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    complete_run();
  end
endmodule : rxagc_top_tb
